// >>> pkg/stamp_cfg.svh
`ifndef STAMP_CFG_SVH
`define STAMP_CFG_SVH

// system clock and counter rate, in Hz
`define CLK_HZ        40000000
`define TICK_HZ       153600

// counter and absolute stamp widths
`define TS_W          48
`define ABS_W         64
`define ABS_SEC_LSB   32
`define ABS_FRAC_LSB  0

// counter steps per sample for each sampling rate
`define STEP_19K2     8
`define STEP_38K4     4

// chain frame: counter in bits 47..0, position in bits 55..48
`define FRAME_LEN     64
`define FRAME_POS_LSB 48
`define CHAIN_MAX     20

// lead of data over the downstream tick edge, in clock cycles
`define TCK_LAG       4

// upstream silence that counts as loss
`define LOSS_CYC      (4 * (`CLK_HZ / `TICK_HZ + 1))

// measurement port for host connections
`define MEAS_PORT     16'hd6d8
`define MAX_CONN      2

`endif

// >>> pkg/stamp_pkg.sv
package stamp_pkg;

    typedef enum logic {
        RATE_19K2 = 1'b0,
        RATE_38K4 = 1'b1
    } rate_e;

    typedef enum logic {
        LINK_NET      = 1'b0,
        LINK_FIELDBUS = 1'b1
    } link_e;

    typedef enum logic [1:0] {
        SYNC_MASTER = 2'b00,
        SYNC_HUNT   = 2'b01,
        SYNC_LOCKED = 2'b10,
        SYNC_LOST   = 2'b11
    } sync_state_e;

endpackage : stamp_pkg

// >>> rtl/rate_tick.sv
`timescale 1ns/1ps
`include "stamp_cfg.svh"

module rate_tick #(
    parameter int CLK_HZ  = `CLK_HZ,
    parameter int TICK_HZ = `TICK_HZ
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // one-cycle tick at the counter rate
    output logic      tick
);
    // fractional accumulator keeps the average rate exact
    localparam logic [31:0] INC = 32'(TICK_HZ);
    localparam logic [31:0] MOD = 32'(CLK_HZ);

    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        acc_d  = acc_q + INC;
        tick_d = 1'b0;
        if (acc_d >= MOD) begin
            acc_d  = acc_d - MOD;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q  <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : rate_tick

// >>> rtl/conn_slots.sv
`timescale 1ns/1ps
`include "stamp_cfg.svh"

module conn_slots #(
    parameter int N    = `MAX_CONN,
    parameter int TS_W = `TS_W,
    parameter int SW   = (N > 1) ? $clog2(N) : 1
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // time base for activity stamps
    input  wire logic [TS_W-1:0] now,
    // requests
    input  wire logic            open,
    input  wire logic [15:0]     port,
    input  wire logic            act,
    input  wire logic [SW-1:0]   act_slot,
    input  wire logic            close,
    input  wire logic [SW-1:0]   close_slot,
    // answers
    output logic                 grant,
    output logic [SW-1:0]        grant_slot,
    output logic                 reject,
    output logic                 drop,
    output logic [SW-1:0]        drop_slot,
    output logic [N-1:0]         active
);
    logic [TS_W-1:0] last_q [N];
    logic [TS_W-1:0] last_d [N];
    logic [N-1:0]    act_q, act_d;
    logic            grant_q, grant_d, reject_q, reject_d, drop_q, drop_d;
    logic [SW-1:0]   gslot_q, gslot_d, dslot_q, dslot_d;

    always_comb begin
        logic            found;
        logic [SW-1:0]   pick;
        logic [TS_W-1:0] age;
        logic [TS_W-1:0] oldest;
        found    = 1'b0;
        pick     = '0;
        age      = '0;
        oldest   = '0;
        last_d   = last_q;
        act_d    = act_q;
        grant_d  = 1'b0;
        reject_d = 1'b0;
        drop_d   = 1'b0;
        gslot_d  = gslot_q;
        dslot_d  = dslot_q;
        if (act && act_q[act_slot]) begin
            last_d[act_slot] = now;  // see [RQ12]
        end
        if (close) begin
            act_d[close_slot] = 1'b0;
        end
        if (open) begin
            if (port != `MEAS_PORT) begin
                reject_d = 1'b1;
            end else begin
                for (int i = N - 1; i >= 0; i--) begin
                    if (!act_d[i]) begin
                        found = 1'b1;
                        pick  = SW'(i);
                    end
                end
                if (!found) begin
                    // wrap-safe age: longest idle slot gives way
                    for (int i = 0; i < N; i++) begin
                        age = now - last_d[i];
                        if (age >= oldest) begin
                            oldest = age;
                            pick   = SW'(i);
                        end
                    end
                    drop_d  = 1'b1;  // see [RQ12]
                    dslot_d = pick;
                end
                act_d[pick]  = 1'b1;  // see [RQ11]
                last_d[pick] = now;
                grant_d      = 1'b1;
                gslot_d      = pick;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                last_q[i] <= '0;
            end
            act_q    <= '0;
            grant_q  <= 1'b0;
            reject_q <= 1'b0;
            drop_q   <= 1'b0;
            gslot_q  <= '0;
            dslot_q  <= '0;
        end else begin
            last_q   <= last_d;
            act_q    <= act_d;
            grant_q  <= grant_d;
            reject_q <= reject_d;
            drop_q   <= drop_d;
            gslot_q  <= gslot_d;
            dslot_q  <= dslot_d;
        end
    end

    assign grant      = grant_q;
    assign grant_slot = gslot_q;
    assign reject     = reject_q;
    assign drop       = drop_q;
    assign drop_slot  = dslot_q;
    assign active     = act_q;

endmodule : conn_slots

// >>> rtl/stamp_counter_sync.sv
// Function
// [RQ1] keep a 48-bit sample counter that advances at 153.6 kHz.
// [RQ2] at 19.2 kHz sampling, consecutive samples differ by 8 counts.
// [RQ3] at 38.4 kHz sampling, consecutive samples differ by 4 counts.
// [RQ4] every measured value leaves with the current counter value.
// [RQ5] the counter is not kept over power loss and restarts from zero.
// [RQ6] the first unit of the chain becomes time master on its own and the others follow.
// [RQ7] a chain holds at most 20 units.
// [RQ8] each chained unit aligns its counter and its bridge carrier to the master.
// [RQ9] the absolute stamp is 64 bits: 32 bits of seconds from 1.1.1990, then 32 bits of fraction.
// [RQ10] the downstream error light always equals the right-hand light of the upstream socket.
// [RQ11] at most two host connections are open on measurement port 55000.
// [RQ12] last activity of each connection is stamped and a third open evicts the longer idle one.
// [RQ13] no automatic correction of filter phase delay between channels is made.
// [RQ14] with network time, each value carries both the counter and the absolute time.
// [RQ15] over fieldbus, no absolute time is sent but the counter still is.
// [RQ16] the counter wraps modulo two to the 48th with no error flag.
// [RQ17] the counter is captured into the sample word in the same cycle as the sample strobe.
`timescale 1ns/1ps
`include "stamp_cfg.svh"

module stamp_counter_sync #(
    parameter int DW       = 24,
    parameter int CARR_BIT = 3
) (
    // clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    // configuration
    input  stamp_pkg::rate_e           RATE_SEL,
    input  stamp_pkg::link_e           LINK_MODE,
    input  wire logic                  ABS_EN,
    // measured value and absolute time from the device
    input  wire logic [DW-1:0]         MEAS_DATA,
    input  wire logic [`ABS_W-1:0]     ABS_TIME,
    // sample word
    output logic                       SMP_STB,
    output logic [`TS_W-1:0]           SMP_CNT,
    output logic [DW-1:0]              SMP_DATA,
    output logic [`ABS_W-1:0]          SMP_ABS,
    output logic                       SMP_ABS_VLD,
    // chain upstream socket
    input  wire logic                  UP_PRESENT,
    input  wire logic                  UP_TCK,
    input  wire logic                  UP_FRM,
    input  wire logic                  UP_DAT,
    input  wire logic                  UP_ERR,
    // chain downstream socket
    output logic                       DN_TCK,
    output logic                       DN_FRM,
    output logic                       DN_DAT,
    output logic                       DN_ERR,
    // status and indicators
    output logic                       IS_MASTER,
    output logic [7:0]                 CHAIN_POS,
    output logic                       CARRIER,
    output logic                       LED_IN_RIGHT,
    output logic                       LED_OUT_GREEN,
    output logic                       LED_OUT_YELLOW,
    // host connections
    input  wire logic                  CONN_OPEN,
    input  wire logic [15:0]           CONN_PORT,
    input  wire logic                  CONN_ACT,
    input  wire logic                  CONN_ACT_SLOT,
    input  wire logic                  CONN_CLOSE,
    input  wire logic                  CONN_CLOSE_SLOT,
    output logic                       CONN_GRANT,
    output logic                       CONN_GRANT_SLOT,
    output logic                       CONN_REJECT,
    output logic                       CONN_DROP,
    output logic                       CONN_DROP_SLOT,
    output logic [`MAX_CONN-1:0]       CONN_ACTIVE
);
    import stamp_pkg::*;

    localparam logic [11:0]      LOSS_MAX  = 12'(`LOSS_CYC);
    localparam logic [5:0]       SLOT_LAST = 6'(`FRAME_LEN - 1);
    localparam logic [`TS_W-1:0] RX_ADV    = `TS_W'(`FRAME_LEN - 1);
    localparam logic [7:0]       POS_LIMIT = 8'(`CHAIN_MAX - 1);

    // step mask decode for the chosen sampling rate
    function automatic logic [`TS_W-1:0] step_mask(input rate_e r);
        if (r == RATE_38K4) begin
            step_mask = `TS_W'(`STEP_38K4 - 1);
        end else begin
            step_mask = `TS_W'(`STEP_19K2 - 1);
        end
    endfunction : step_mask

    // upstream pins pass two flip-flops; third stage only for tick edges
    logic [4:0] pin_s1_q, pin_s1_d, pin_s2_q;
    logic       tck_s3_q;
    logic       up_present, up_tck, up_frm, up_dat, up_err, up_edge;

    always_comb begin
        pin_s1_d = {UP_PRESENT, UP_TCK, UP_FRM, UP_DAT, UP_ERR};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            tck_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s1_q;
            tck_s3_q <= pin_s2_q[3];
        end
    end

    assign up_present = pin_s2_q[4];
    assign up_tck     = pin_s2_q[3];
    assign up_frm     = pin_s2_q[2];
    assign up_dat     = pin_s2_q[1];
    assign up_err     = pin_s2_q[0];
    assign up_edge    = up_tck ^ tck_s3_q;

    // local rate source
    logic gen_tick;

    rate_tick #(
        .CLK_HZ  (`CLK_HZ),
        .TICK_HZ (`TICK_HZ)
    ) u_rate_tick (
        .clk  (CLK_SYS),
        .rst  (RST),
        .tick (gen_tick)
    );

    // counter, chain frame and role
    sync_state_e       state_q, state_d;
    logic [`TS_W-1:0]  cnt_q, cnt_d;
    logic [5:0]        slot_q, slot_d;
    logic [63:0]       rx_q, rx_d, tx_q, tx_d;
    logic [7:0]        pos_q, pos_d;
    logic [11:0]       loss_q, loss_d;
    logic              long_q, long_d;
    logic              tick;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        slot_d  = slot_q;
        rx_d    = rx_q;
        tx_d    = tx_q;
        pos_d   = pos_q;
        loss_d  = loss_q;
        long_d  = long_q;
        tick    = 1'b0;
        case (state_q)
            SYNC_MASTER: begin
                tick   = gen_tick;
                pos_d  = 8'h00;
                long_d = 1'b0;
                if (up_present) begin  // see [RQ6]
                    state_d = SYNC_HUNT;
                    loss_d  = 12'h000;
                end
            end
            SYNC_HUNT, SYNC_LOCKED: begin
                tick   = up_edge;  // see [RQ8]
                loss_d = up_edge ? 12'h000 : ((loss_q == LOSS_MAX) ? loss_q : loss_q + 12'h001);
                if (!up_present) begin
                    state_d = SYNC_MASTER;  // see [RQ6]
                end else if (loss_q == LOSS_MAX) begin
                    state_d = SYNC_LOST;
                end
            end
            SYNC_LOST: begin
                tick = gen_tick;
                if (!up_present) begin
                    state_d = SYNC_MASTER;
                end else if (up_edge) begin
                    state_d = SYNC_HUNT;
                    loss_d  = 12'h000;
                end
            end
            default: begin
                state_d = SYNC_MASTER;
            end
        endcase
        if (tick) begin
            cnt_d  = cnt_q + `TS_W'(1);  // see [RQ1] [RQ16]
            slot_d = slot_q + 6'h01;
            if (state_q == SYNC_HUNT || state_q == SYNC_LOCKED) begin
                if (up_frm) begin
                    slot_d = 6'h00;
                    if (state_q == SYNC_HUNT && state_d == SYNC_HUNT) begin
                        state_d = SYNC_LOCKED;
                    end
                end
                rx_d[slot_d] = up_dat;
                if (state_q == SYNC_LOCKED && slot_d == SLOT_LAST) begin
                    // upstream counter stood at rx word on slot zero
                    cnt_d  = rx_d[`TS_W-1:0] + RX_ADV;  // see [RQ8]
                    pos_d  = (rx_d[`FRAME_POS_LSB +: 8] == 8'hff) ? 8'hff : rx_d[`FRAME_POS_LSB +: 8] + 8'h01;
                    long_d = rx_d[`FRAME_POS_LSB +: 8] >= POS_LIMIT;  // see [RQ7]
                end
            end
            if (slot_d == 6'h00) begin
                tx_d = {8'h00, pos_d, cnt_d};
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= SYNC_MASTER;
            cnt_q   <= '0;  // see [RQ5]
            slot_q  <= 6'h00;
            rx_q    <= 64'h0;
            tx_q    <= 64'h0;
            pos_q   <= 8'h00;
            loss_q  <= 12'h000;
            long_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            slot_q  <= slot_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            pos_q   <= pos_d;
            loss_q  <= loss_d;
            long_q  <= long_d;
        end
    end

    // downstream link, status and indicators
    logic [`TCK_LAG-1:0] lag_q, lag_d;
    logic                dn_tck_q, dn_tck_d, dn_frm_q, dn_frm_d, dn_dat_q, dn_dat_d;
    logic                err_q, err_d, green_q, master_q, master_d, carr_q, carr_d;
    logic [7:0]          cpos_q;

    always_comb begin
        // data settles before the tick edge it belongs to
        lag_d    = {lag_q[`TCK_LAG-2:0], tick};
        dn_tck_d = dn_tck_q ^ lag_q[`TCK_LAG-1];
        dn_frm_d = dn_frm_q;
        dn_dat_d = dn_dat_q;
        if (tick) begin
            dn_frm_d = (slot_d == 6'h00);
            dn_dat_d = tx_d[slot_d];
        end
        err_d    = long_d || (state_d == SYNC_LOST) || (state_d != SYNC_MASTER && up_err);  // see [RQ10]
        master_d = (state_d == SYNC_MASTER);
        carr_d   = cnt_d[CARR_BIT];  // see [RQ8]
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            lag_q    <= '0;
            dn_tck_q <= 1'b0;
            dn_frm_q <= 1'b0;
            dn_dat_q <= 1'b0;
            err_q    <= 1'b0;
            green_q  <= 1'b0;
            master_q <= 1'b1;
            carr_q   <= 1'b0;
            cpos_q   <= 8'h00;
        end else begin
            lag_q    <= lag_d;
            dn_tck_q <= dn_tck_d;
            dn_frm_q <= dn_frm_d;
            dn_dat_q <= dn_dat_d;
            err_q    <= err_d;
            green_q  <= 1'b1;
            master_q <= master_d;
            carr_q   <= carr_d;
            cpos_q   <= master_d ? 8'h00 : pos_d;
        end
    end

    assign DN_TCK         = dn_tck_q;
    assign DN_FRM         = dn_frm_q;
    assign DN_DAT         = dn_dat_q;
    assign DN_ERR         = err_q;
    assign IS_MASTER      = master_q;
    assign CHAIN_POS      = cpos_q;
    assign CARRIER        = carr_q;
    assign LED_IN_RIGHT   = err_q;
    assign LED_OUT_GREEN  = green_q;
    assign LED_OUT_YELLOW = err_q;  // see [RQ10]

    // sample word: raw value, no phase alignment between filters
    logic                smp_stb_q, smp_stb_d, abs_vld_q, abs_vld_d;
    logic [`TS_W-1:0]    smp_cnt_q, smp_cnt_d;
    logic [DW-1:0]       smp_dat_q, smp_dat_d;
    logic [`ABS_W-1:0]   smp_abs_q, smp_abs_d;

    always_comb begin
        smp_stb_d = tick && ((cnt_d & step_mask(RATE_SEL)) == '0);  // see [RQ2] [RQ3]
        smp_cnt_d = smp_cnt_q;
        smp_dat_d = smp_dat_q;
        abs_vld_d = abs_vld_q;
        smp_abs_d = smp_abs_q;
        if (smp_stb_d) begin
            smp_cnt_d = cnt_d;  // see [RQ4] [RQ17] [RQ15]
            smp_dat_d = MEAS_DATA;  // see [RQ13]
            abs_vld_d = ABS_EN && (LINK_MODE == LINK_NET);  // see [RQ14] [RQ15]
            smp_abs_d = abs_vld_d ? ABS_TIME : '0;  // see [RQ9]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            smp_stb_q <= 1'b0;
            smp_cnt_q <= '0;
            smp_dat_q <= '0;
            abs_vld_q <= 1'b0;
            smp_abs_q <= '0;
        end else begin
            smp_stb_q <= smp_stb_d;
            smp_cnt_q <= smp_cnt_d;
            smp_dat_q <= smp_dat_d;
            abs_vld_q <= abs_vld_d;
            smp_abs_q <= smp_abs_d;
        end
    end

    assign SMP_STB     = smp_stb_q;
    assign SMP_CNT     = smp_cnt_q;
    assign SMP_DATA    = smp_dat_q;
    assign SMP_ABS     = smp_abs_q;
    assign SMP_ABS_VLD = abs_vld_q;

    // host connections on the measurement port, stamped by the counter
    conn_slots #(
        .N    (`MAX_CONN),
        .TS_W (`TS_W),
        .SW   (1)
    ) u_conn_slots (
        .clk        (CLK_SYS),
        .rst        (RST),
        .now        (cnt_q),
        .open       (CONN_OPEN),
        .port       (CONN_PORT),
        .act        (CONN_ACT),
        .act_slot   (CONN_ACT_SLOT),
        .close      (CONN_CLOSE),
        .close_slot (CONN_CLOSE_SLOT),
        .grant      (CONN_GRANT),
        .grant_slot (CONN_GRANT_SLOT),
        .reject     (CONN_REJECT),
        .drop       (CONN_DROP),
        .drop_slot  (CONN_DROP_SLOT),
        .active     (CONN_ACTIVE)
    );

endmodule : stamp_counter_sync

// >>> test/up_unit.sv
`timescale 1ns/1ps

module up_unit #(
    parameter int HALF = 40
) (
    // clock and frame content
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [47:0] base,
    input  wire logic [7:0]  pos,
    // chain pins
    output logic             tck,
    output logic             frm,
    output logic             dat
);
    logic [63:0] word;
    logic [47:0] cnt;
    int          k;

    initial begin
        tck = 1'b0;
        frm = 1'b0;
        dat = 1'b0;
        k   = 0;
        cnt = '0;
        forever begin
            @(posedge clk);
            #1;
            if (!run) begin
                frm = 1'b0;
                dat = ~dat;
                cnt = base;
                k   = 0;
            end else begin
                if (k == 0) word = {8'h00, pos, cnt};
                frm = (k == 0);
                dat = word[k];
                repeat (HALF) @(posedge clk);
                #1;
                tck = ~tck;
                k   = (k + 1) % 64;
                if (k == 0) cnt = cnt + 48'h40;
                repeat (HALF - 1) @(posedge clk);
            end
        end
    end
endmodule : up_unit

// >>> test/stamp_counter_sync_properties.sv
`timescale 1ns/1ps
`include "stamp_cfg.svh"

module stamp_props #(
    parameter int DW = 24
) (
    input wire logic             CLK_SYS,
    input wire logic             RST,
    input stamp_pkg::rate_e      RATE_SEL,
    input stamp_pkg::link_e      LINK_MODE,
    input wire logic             ABS_EN,
    input wire logic [DW-1:0]    MEAS_DATA,
    input wire logic [`ABS_W-1:0] ABS_TIME,
    input wire logic             SMP_STB,
    input wire logic [`TS_W-1:0] SMP_CNT,
    input wire logic [DW-1:0]    SMP_DATA,
    input wire logic [`ABS_W-1:0] SMP_ABS,
    input wire logic             SMP_ABS_VLD,
    input wire logic             DN_ERR,
    input wire logic             IS_MASTER,
    input wire logic [7:0]       CHAIN_POS,
    input wire logic             LED_IN_RIGHT,
    input wire logic             LED_OUT_GREEN,
    input wire logic             LED_OUT_YELLOW,
    input wire logic             CONN_OPEN,
    input wire logic [15:0]      CONN_PORT,
    input wire logic             CONN_GRANT,
    input wire logic             CONN_REJECT,
    input wire logic             CONN_DROP
);
    import stamp_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    logic [`TS_W-1:0] last_q, last_d;
    logic             arm_q, arm_d;
    rate_e            rate_q, rate_d;
    always_comb begin
        last_d = last_q;
        arm_d  = arm_q;
        rate_d = rate_q;
        if (SMP_STB) begin
            last_d = SMP_CNT;
            arm_d  = IS_MASTER;
            rate_d = RATE_SEL;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            last_q <= '0;
            arm_q  <= 1'b0;
            rate_q <= RATE_19K2;
        end else begin
            last_q <= last_d;
            arm_q  <= arm_d;
            rate_q <= rate_d;
        end
    end

    a_stb_one_cycle: assert property (SMP_STB |=> !SMP_STB) else $error("strobe too long");
    a_step_size: assert property (SMP_STB && arm_q && IS_MASTER && rate_q == RATE_SEL && $stable(RATE_SEL)
        |-> SMP_CNT - last_q == ((RATE_SEL == RATE_38K4) ? 48'h4 : 48'h8))
        else $error("step wrong");
    a_cnt_holds: assert property (!SMP_STB |-> $stable(SMP_CNT)) else $error("count moved");
    a_data_capture: assert property (SMP_STB |-> SMP_DATA == $past(MEAS_DATA))
        else $error("data not captured");
    a_abs_gate: assert property (SMP_STB |-> SMP_ABS_VLD == $past(ABS_EN && LINK_MODE == LINK_NET))
        else $error("abs valid wrong");
    a_abs_value: assert property (SMP_STB |-> SMP_ABS == (SMP_ABS_VLD ? $past(ABS_TIME) : 64'h0))
        else $error("absolute stamp wrong");
    a_err_mirror: assert property (LED_OUT_YELLOW == LED_IN_RIGHT && DN_ERR == LED_IN_RIGHT)
        else $error("error lights differ");
    a_master_pos: assert property (IS_MASTER |-> CHAIN_POS == 8'h00) else $error("master not at zero");
    a_reject_cause: assert property (CONN_REJECT |-> $past(CONN_OPEN && CONN_PORT != `MEAS_PORT))
        else $error("bad reject");
    a_open_answer: assert property (CONN_OPEN |=> CONN_GRANT ^ CONN_REJECT) else $error("open not answered");
    a_green_on: assert property (!$past(RST) |-> LED_OUT_GREEN) else $error("green indicator off");

    c_strobe: cover property (SMP_STB);
    c_drop: cover property (CONN_DROP);
    c_follower: cover property (!IS_MASTER && SMP_STB);
endmodule : stamp_props

bind stamp_counter_sync stamp_props #(.DW(DW)) props_u (.*);

// >>> test/tb_stamp_counter_sync.sv
`timescale 1ns/1ps
`include "stamp_cfg.svh"

module tb_stamp_counter_sync;
    import stamp_pkg::*;
    logic CLK_SYS, RST, ABS_EN, SMP_STB, SMP_ABS_VLD, UP_PRESENT, UP_TCK, UP_FRM, UP_DAT, UP_ERR, run;
    logic DN_TCK, DN_FRM, DN_DAT, DN_ERR, IS_MASTER, CARRIER, LED_IN_RIGHT, LED_OUT_GREEN, LED_OUT_YELLOW;
    logic CONN_OPEN, CONN_ACT, CONN_ACT_SLOT, CONN_CLOSE, CONN_CLOSE_SLOT, CONN_GRANT, CONN_GRANT_SLOT;
    logic CONN_REJECT, CONN_DROP, CONN_DROP_SLOT;
    logic [1:0]  CONN_ACTIVE;
    logic [15:0] CONN_PORT;
    logic [7:0]  CHAIN_POS, pos;
    logic [23:0] MEAS_DATA, SMP_DATA;
    logic [47:0] SMP_CNT, c0, base;
    logic [63:0] ABS_TIME, SMP_ABS;
    rate_e       RATE_SEL;
    link_e       LINK_MODE;
    int          n_fail, checked, gap;

    stamp_counter_sync #(.DW(24), .CARR_BIT(3)) dut_u (.*);
    up_unit #(.HALF(40)) up_u (.clk(CLK_SYS), .run(run), .base(base), .pos(pos), .tck(UP_TCK), .frm(UP_FRM),
        .dat(UP_DAT));

    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : step

    task automatic wait_stb;
        gap = 0;
        do begin
            step(1);
            gap++;
        end while (SMP_STB !== 1'b1 && gap < 3000);
        chk("strobe", SMP_STB, 1'b1);
    endtask : wait_stb

    task automatic t_rates;
        wait_stb();
        chk("first count", SMP_CNT, 48'h8);
        chk("carrier", CARRIER, 1'b1);
        chk("data", SMP_DATA, MEAS_DATA);
        c0 = SMP_CNT;
        MEAS_DATA = 24'h5a5a5a;
        wait_stb();
        chk("step 8", SMP_CNT - c0, 48'h8);
        chk("tick rate", (gap >= 2080 && gap <= 2087), 1'b1);
        chk("data", SMP_DATA, 24'h5a5a5a);
        RATE_SEL = RATE_38K4;
        wait_stb();
        c0 = SMP_CNT;
        wait_stb();
        chk("step 4", SMP_CNT - c0, 48'h4);
        chk("tick rate", (gap >= 1039 && gap <= 1043), 1'b1);
    endtask : t_rates

    task automatic t_abs;
        ABS_EN = 1'b1;
        wait_stb();
        wait_stb();
        chk("abs valid", SMP_ABS_VLD, 1'b1);
        chk("abs time", SMP_ABS, ABS_TIME);
        LINK_MODE = LINK_FIELDBUS;
        c0 = SMP_CNT;
        wait_stb();
        chk("abs valid", SMP_ABS_VLD, 1'b0);
        chk("abs time", SMP_ABS, 64'h0);
        chk("count kept", SMP_CNT - c0, 48'h4);
    endtask : t_abs

    task automatic open_req(input logic [15:0] p);
        CONN_PORT = p;
        CONN_OPEN = 1'b1;
        step(1);
        CONN_OPEN = 1'b0;
    endtask : open_req

    task automatic t_conn;
        open_req(16'hd6d8);
        chk("grant slot0", {CONN_GRANT, CONN_GRANT_SLOT}, 2'b10);
        open_req(16'hd6d8);
        chk("grant slot1", {CONN_GRANT, CONN_GRANT_SLOT, CONN_ACTIVE}, 4'b1111);
        open_req(16'h0050);
        chk("reject", {CONN_REJECT, CONN_GRANT, CONN_ACTIVE}, 4'b1011);
        wait_stb();
        CONN_ACT_SLOT = 1'b1;
        CONN_ACT = 1'b1;
        step(1);
        CONN_ACT = 1'b0;
        wait_stb();
        open_req(16'hd6d8);
        chk("evict idle", {CONN_GRANT, CONN_DROP, CONN_DROP_SLOT, CONN_GRANT_SLOT}, 4'b1100);
        CONN_CLOSE_SLOT = 1'b1;
        CONN_CLOSE = 1'b1;
        step(1);
        CONN_CLOSE = 1'b0;
        chk("close", CONN_ACTIVE, 2'b01);
    endtask : t_conn

    task automatic t_chain;
        UP_PRESENT = 1'b1;
        run = 1'b1;
        step(11000);
        chk("follower", {IS_MASTER, CHAIN_POS}, 9'h001);
        wait_stb();
        chk("aligned", SMP_CNT[47:16], 32'h12345678);
        chk("no error", LED_OUT_YELLOW, 1'b0);
        UP_ERR = 1'b1;
        step(6);
        chk("error out", {LED_OUT_GREEN, LED_OUT_YELLOW, LED_IN_RIGHT, DN_ERR}, 4'hf);
        UP_ERR = 1'b0;
        pos = 8'h13;
        step(11000);
        chk("chain too long", LED_OUT_YELLOW, 1'b1);
    endtask : t_chain

    initial begin
        {n_fail, checked} = '0;
        {RST, ABS_EN, UP_PRESENT, UP_ERR, run, CONN_OPEN, CONN_ACT, CONN_CLOSE} = 8'h80;
        {CONN_ACT_SLOT, CONN_CLOSE_SLOT, CONN_PORT, pos} = '0;
        RATE_SEL = RATE_19K2;
        LINK_MODE = LINK_NET;
        MEAS_DATA = 24'h123abc;
        ABS_TIME = 64'h0102030480000000;
        base = 48'h123456780000;
        step(6);
        chk("reset count", SMP_CNT, 48'h0);
        chk("reset master", IS_MASTER, 1'b1);
        RST = 1'b0;
        t_rates();
        t_abs();
        t_conn();
        t_chain();
        give_verdict();
    end

    initial begin
        repeat (90000) @(posedge CLK_SYS);
        n_fail++;
        give_verdict();
    end
endmodule : tb_stamp_counter_sync
